/* design/acfd_map.vh */
// constants for the arithmetic clause flow decoder
`ifndef ACFD_MAP_VH
`define ACFD_MAP_VH

// ----------------------------------------------------------------
// flow opcode values
// ----------------------------------------------------------------
`define ACFD_OP_W 4
`define ACFD_OP_PLAIN 4'h8
`define ACFD_OP_FIRST_PUSH 4'h9
`define ACFD_OP_SINGLE_POP 4'hA
`define ACFD_OP_DOUBLE_POP 4'hB
`define ACFD_OP_FOUR_WORD 4'hC
`define ACFD_OP_LOOP_SKIP 4'hD
`define ACFD_OP_LOOP_EXIT 4'hE
`define ACFD_OP_PUSH_INVERT 4'hF

// ----------------------------------------------------------------
// field layout, low word (offset +0, or +8 in the four word form)
// ----------------------------------------------------------------
`define ACFD_ADDR_LSB 0
`define ACFD_ADDR_W 22
`define ACFD_IDX_LSB 4
`define ACFD_BANK_A_LSB 22
`define ACFD_BANK_B_LSB 26
`define ACFD_BANK_W 4
`define ACFD_MODE_A_LSB 30
`define ACFD_MODE_W 2

// ----------------------------------------------------------------
// field layout, high word (offset +4, or +12 in the four word form)
// ----------------------------------------------------------------
`define ACFD_MODE_B_LSB 0
`define ACFD_CBA_A_LSB 2
`define ACFD_CBA_B_LSB 10
`define ACFD_CBA_W 8
`define ACFD_COUNT_LSB 18
`define ACFD_COUNT_W 7
`define ACFD_OPC_LSB 26

// ----------------------------------------------------------------
// predicate handling modes and reset values
// ----------------------------------------------------------------
`define ACFD_PM_W 3
`define ACFD_PM_UPDATE 3'h0
`define ACFD_PM_FIRST_PUSH 3'h1
`define ACFD_PM_PUSH_EACH 3'h2
`define ACFD_PM_LOOP_EXIT 3'h3
`define ACFD_PM_LOOP_SKIP 3'h4
`define ACFD_POP_W 2
`define ACFD_RST_ZERO 1'h0

`endif

/* design/acfd_word_split.v */
// splits one pair of clause words into its fields
`timescale 1ns/1ps
`default_nettype none
`include "acfd_map.vh"

module acfd_word_split (
    input wire [31:0] word_lo,
    input wire [31:0] word_hi,
    output wire [`ACFD_ADDR_W-1:0] addr,
    output wire [`ACFD_BANK_W-1:0] bank_a,
    output wire [`ACFD_BANK_W-1:0] bank_b,
    output wire [`ACFD_MODE_W-1:0] mode_a,
    output wire [`ACFD_MODE_W-1:0] mode_b,
    output wire [`ACFD_CBA_W-1:0] cba_a,
    output wire [`ACFD_CBA_W-1:0] cba_b,
    output wire [`ACFD_COUNT_W-1:0] count,
    output wire [`ACFD_OP_W-1:0] opcode,
    output wire [15:0] idx_sel
);

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    // the same slicing serves the normal and the extension pair,
    // since buffers two and three sit where zero and one sit
    assign addr = word_lo[`ACFD_ADDR_LSB +: `ACFD_ADDR_W];
    assign idx_sel = word_lo[`ACFD_IDX_LSB +: 16]; // only ext pair
    assign bank_a = word_lo[`ACFD_BANK_A_LSB +: `ACFD_BANK_W];
    assign bank_b = word_lo[`ACFD_BANK_B_LSB +: `ACFD_BANK_W];
    assign mode_a = word_lo[`ACFD_MODE_A_LSB +: `ACFD_MODE_W];
    assign mode_b = word_hi[`ACFD_MODE_B_LSB +: `ACFD_MODE_W];
    assign cba_a = word_hi[`ACFD_CBA_A_LSB +: `ACFD_CBA_W];
    assign cba_b = word_hi[`ACFD_CBA_B_LSB +: `ACFD_CBA_W];
    assign count = word_hi[`ACFD_COUNT_LSB +: `ACFD_COUNT_W];
    assign opcode = word_hi[`ACFD_OPC_LSB +: `ACFD_OP_W];

endmodule

`default_nettype wire

/* design/acfd_decoder.v */
// arithmetic clause flow decoder: opcode decode and predicate control
`timescale 1ns/1ps
`default_nettype none
`include "acfd_map.vh"

// What this block does
// - plain start: predicate ops update, no stack
// - loop exit start: predicate ops break unmasked pixels
// - loop skip start: predicate ops continue unmasked pixels
// - loop variants: address names the loop terminator
// - loop variants: push, clause, else, continue, pop
// - invert start: push then update, else after
// - four word opcode opens an instruction pair
// - extension words first, clause words at +8, +12
// - extension carries buffers two, three settings
// - single pop start: pop once after clause
// - double pop start: pop twice after clause
// - first push start: first op pushes and updates, rest update
// - first push start is opcode nine
module acfd_decoder (
    input wire clock,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [31:0] in_word_lo,
    input wire [31:0] in_word_hi,
    input wire predicate_set_op_op,
    input wire clause_done,
    output reg dec_valid_q,
    output reg bad_op_q,
    output reg [`ACFD_ADDR_W-1:0] clause_addr_q,
    output reg [`ACFD_COUNT_W-1:0] clause_count_q,
    output reg addr_is_loop_end_q,
    output reg start_push_q,
    output reg else_after_q,
    output reg [`ACFD_POP_W-1:0] pop_after_q,
    output reg [`ACFD_PM_W-1:0] pred_mode_q,
    output reg four_word_q,
    output reg [4*`ACFD_BANK_W-1:0] cb_bank_q,
    output reg [4*`ACFD_CBA_W-1:0] cb_addr_q,
    output reg [4*`ACFD_MODE_W-1:0] cb_mode_q,
    output reg [15:0] cb_idx_sel_q,
    output reg ps_valid_q,
    output reg ps_push_q,
    output reg ps_update_q,
    output reg ps_break_q,
    output reg ps_cont_q,
    output reg end_valid_q,
    output reg end_else_q,
    output reg end_cont_q,
    output reg [`ACFD_POP_W-1:0] end_pop_q
);

    // ------------------------------------------------------------
    // states and opcode helpers
    // ------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_EXT = 3'b010;
    localparam [2:0] S_RUN = 3'b100;

    // opcodes that start a clause directly
    function is_clause_op;
        input [`ACFD_OP_W-1:0] op;
        begin
            case (op)
                `ACFD_OP_PLAIN, `ACFD_OP_FIRST_PUSH,
                `ACFD_OP_SINGLE_POP, `ACFD_OP_DOUBLE_POP,
                `ACFD_OP_LOOP_SKIP, `ACFD_OP_LOOP_EXIT,
                `ACFD_OP_PUSH_INVERT: is_clause_op = 1'b1;
                default: is_clause_op = 1'b0;
            endcase
        end
    endfunction

    // predicate handling chosen by the opcode
    function [`ACFD_PM_W-1:0] pred_mode_of;
        input [`ACFD_OP_W-1:0] op;
        begin
            case (op)
                `ACFD_OP_FIRST_PUSH: pred_mode_of = `ACFD_PM_FIRST_PUSH;
                `ACFD_OP_PUSH_INVERT: pred_mode_of = `ACFD_PM_PUSH_EACH;
                `ACFD_OP_LOOP_EXIT: pred_mode_of = `ACFD_PM_LOOP_EXIT;
                `ACFD_OP_LOOP_SKIP: pred_mode_of = `ACFD_PM_LOOP_SKIP;
                default: pred_mode_of = `ACFD_PM_UPDATE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // field split of the presented pair
    // ------------------------------------------------------------
    wire [`ACFD_ADDR_W-1:0] f_addr;
    wire [`ACFD_BANK_W-1:0] f_bank_a;
    wire [`ACFD_BANK_W-1:0] f_bank_b;
    wire [`ACFD_MODE_W-1:0] f_mode_a;
    wire [`ACFD_MODE_W-1:0] f_mode_b;
    wire [`ACFD_CBA_W-1:0] f_cba_a;
    wire [`ACFD_CBA_W-1:0] f_cba_b;
    wire [`ACFD_COUNT_W-1:0] f_count;
    wire [`ACFD_OP_W-1:0] f_op;
    wire [15:0] f_idx;

    acfd_word_split u_split (
        .word_lo(in_word_lo),
        .word_hi(in_word_hi),
        .addr(f_addr),
        .bank_a(f_bank_a),
        .bank_b(f_bank_b),
        .mode_a(f_mode_a),
        .mode_b(f_mode_b),
        .cba_a(f_cba_a),
        .cba_b(f_cba_b),
        .count(f_count),
        .opcode(f_op),
        .idx_sel(f_idx)
    );

    // ------------------------------------------------------------
    // state and held extension fields
    // ------------------------------------------------------------
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [2*`ACFD_BANK_W-1:0] ext_bank_q;
    reg [2*`ACFD_CBA_W-1:0] ext_cba_q;
    reg [2*`ACFD_MODE_W-1:0] ext_mode_q;
    reg [15:0] ext_idx_q;
    reg first_seen_q;

    // a new pair is only taken while no clause is in flight
    assign in_ready = state_q[0] | state_q[1];

    wire take = in_valid & in_ready;
    wire is_ext = (f_op == `ACFD_OP_FOUR_WORD);
    wire start_ok = take & is_clause_op(f_op);
    wire loop_op = (f_op == `ACFD_OP_LOOP_EXIT) |
        (f_op == `ACFD_OP_LOOP_SKIP);

    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (take & is_ext) begin
                    state_d = S_EXT;
                end else if (start_ok) begin
                    state_d = S_RUN;
                end
            end
            S_EXT: begin
                // a second extension pair or junk drops the pair
                if (start_ok) begin
                    state_d = S_RUN;
                end else if (take) begin
                    state_d = S_IDLE;
                end
            end
            S_RUN: begin
                if (clause_done) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // extension pair capture
    // ------------------------------------------------------------
    // extension words arrive first, at the lower offsets
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_bank_q <= {2*`ACFD_BANK_W{`ACFD_RST_ZERO}};
            ext_cba_q <= {2*`ACFD_CBA_W{`ACFD_RST_ZERO}};
            ext_mode_q <= {2*`ACFD_MODE_W{`ACFD_RST_ZERO}};
            ext_idx_q <= 16'h0000;
        end else if (take & is_ext & state_q[0]) begin
            ext_bank_q <= {f_bank_b, f_bank_a};
            ext_cba_q <= {f_cba_b, f_cba_a};
            ext_mode_q <= {f_mode_b, f_mode_a};
            ext_idx_q <= f_idx;
        end
    end

    // ------------------------------------------------------------
    // clause start decode
    // ------------------------------------------------------------
    // everything is registered on the accepting edge together
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dec_valid_q <= 1'b0;
            bad_op_q <= 1'b0;
            clause_addr_q <= {`ACFD_ADDR_W{`ACFD_RST_ZERO}};
            clause_count_q <= {`ACFD_COUNT_W{`ACFD_RST_ZERO}};
            addr_is_loop_end_q <= 1'b0;
            start_push_q <= 1'b0;
            else_after_q <= 1'b0;
            pop_after_q <= {`ACFD_POP_W{`ACFD_RST_ZERO}};
            pred_mode_q <= `ACFD_PM_UPDATE;
            four_word_q <= 1'b0;
            cb_bank_q <= {4*`ACFD_BANK_W{`ACFD_RST_ZERO}};
            cb_addr_q <= {4*`ACFD_CBA_W{`ACFD_RST_ZERO}};
            cb_mode_q <= {4*`ACFD_MODE_W{`ACFD_RST_ZERO}};
            cb_idx_sel_q <= 16'h0000;
        end else begin
            dec_valid_q <= start_ok;
            bad_op_q <= take & ~start_ok & ~(is_ext & state_q[0]);
            if (start_ok) begin
                clause_addr_q <= f_addr;
                clause_count_q <= f_count;
                addr_is_loop_end_q <= loop_op;
                pred_mode_q <= pred_mode_of(f_op);
                // loop variants wrap the clause in push and pop
                start_push_q <= loop_op;
                else_after_q <= loop_op |
                    (f_op == `ACFD_OP_PUSH_INVERT);
                if (f_op == `ACFD_OP_DOUBLE_POP) begin
                    pop_after_q <= 2'd2;
                end else if ((f_op == `ACFD_OP_SINGLE_POP) | loop_op) begin
                    pop_after_q <= 2'd1;
                end else begin
                    pop_after_q <= 2'd0;
                end
                four_word_q <= state_q[1];
                cb_bank_q <= {state_q[1] ? ext_bank_q :
                    {2*`ACFD_BANK_W{1'b0}}, f_bank_b, f_bank_a};
                cb_addr_q <= {state_q[1] ? ext_cba_q :
                    {2*`ACFD_CBA_W{1'b0}}, f_cba_b, f_cba_a};
                cb_mode_q <= {state_q[1] ? ext_mode_q :
                    {2*`ACFD_MODE_W{1'b0}}, f_mode_b, f_mode_a};
                cb_idx_sel_q <= state_q[1] ? ext_idx_q : 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // per predicate-set operation actions
    // ------------------------------------------------------------
    // ops outside a running clause are ignored, not queued
    wire ps_take = predicate_set_op_op & state_q[2];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ps_valid_q <= 1'b0;
            ps_push_q <= 1'b0;
            ps_update_q <= 1'b0;
            ps_break_q <= 1'b0;
            ps_cont_q <= 1'b0;
            first_seen_q <= 1'b0;
        end else begin
            ps_valid_q <= ps_take;
            ps_push_q <= 1'b0;
            ps_update_q <= 1'b0;
            ps_break_q <= 1'b0;
            ps_cont_q <= 1'b0;
            if (dec_valid_q) begin
                first_seen_q <= 1'b0;
            end
            if (ps_take) begin
                first_seen_q <= 1'b1;
                case (pred_mode_q)
                    `ACFD_PM_FIRST_PUSH: begin
                        // an op in the decode cycle is the first one
                        ps_push_q <= ~first_seen_q | dec_valid_q;
                        ps_update_q <= 1'b1;
                    end
                    `ACFD_PM_PUSH_EACH: begin
                        ps_push_q <= 1'b1;
                        ps_update_q <= 1'b1;
                    end
                    `ACFD_PM_LOOP_EXIT: ps_break_q <= 1'b1;
                    `ACFD_PM_LOOP_SKIP: ps_cont_q <= 1'b1;
                    default: ps_update_q <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // end of clause actions
    // ------------------------------------------------------------
    // else, continue and pops reported in one pulse; the engine
    // applies them in that order
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            end_valid_q <= 1'b0;
            end_else_q <= 1'b0;
            end_cont_q <= 1'b0;
            end_pop_q <= {`ACFD_POP_W{`ACFD_RST_ZERO}};
        end else begin
            end_valid_q <= state_q[2] & clause_done;
            end_else_q <= state_q[2] & clause_done & else_after_q;
            end_cont_q <= state_q[2] & clause_done &
                addr_is_loop_end_q;
            end_pop_q <= (state_q[2] & clause_done) ? pop_after_q :
                {`ACFD_POP_W{1'b0}};
        end
    end

endmodule

`default_nettype wire

/* verif/acfd_checker.sv */
// port assertions for the clause flow decoder
`timescale 1ns/1ps
`default_nettype none
module acfd_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [31:0] in_word_lo,
    input wire logic [31:0] in_word_hi,
    input wire logic predicate_set_op_op,
    input wire logic clause_done,
    input wire logic dec_valid_q,
    input wire logic [21:0] clause_addr_q,
    input wire logic addr_is_loop_end_q,
    input wire logic start_push_q,
    input wire logic else_after_q,
    input wire logic [1:0] pop_after_q,
    input wire logic [2:0] pred_mode_q,
    input wire logic ps_valid_q,
    input wire logic end_valid_q
);
    // ------------------------------
    // helpers
    // ------------------------------
    // a pair only counts when the decoder is ready
    wire take = in_valid & in_ready;
    wire [3:0] op = in_word_hi[29:26];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------
    // decode results
    // ------------------------------
    property p_plain;
        take && op == 4'h8 |=> dec_valid_q && pred_mode_q == 3'h0
            && !start_push_q && pop_after_q == 2'h0 && !else_after_q;
    endproperty
    a_plain: assert property (p_plain)
        else $error("plain start decoded wrongly");
    property p_exit;
        take && op == 4'hE |=> pred_mode_q == 3'h3 && start_push_q
            && else_after_q && pop_after_q == 2'h1 && addr_is_loop_end_q;
    endproperty
    a_exit: assert property (p_exit)
        else $error("loop exit start decoded wrongly");
    property p_skip;
        take && op == 4'hD |=> pred_mode_q == 3'h4 && start_push_q
            && else_after_q && pop_after_q == 2'h1 && addr_is_loop_end_q;
    endproperty
    a_skip: assert property (p_skip)
        else $error("loop skip start decoded wrongly");
    property p_invert;
        take && op == 4'hF |=> pred_mode_q == 3'h2 && else_after_q
            && pop_after_q == 2'h0;
    endproperty
    a_invert: assert property (p_invert)
        else $error("push invert start decoded wrongly");
    // bit 26 separates the single and double pop codes
    property p_pops;
        take && (op == 4'hA || op == 4'hB) |=>
            pop_after_q == {1'b0, $past(in_word_hi[26])} + 2'h1;
    endproperty
    a_pops: assert property (p_pops)
        else $error("pop count after clause wrong");
    property p_first;
        take && op == 4'h9 |=> dec_valid_q && pred_mode_q == 3'h1;
    endproperty
    a_first: assert property (p_first)
        else $error("first push start decoded wrongly");
    property p_ext;
        take && op == 4'hC |=> !dec_valid_q && in_ready;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extension pair answered or blocked");
    property p_addr;
        take && op == 4'h8 |=> clause_addr_q == $past(in_word_lo[21:0])
            ##1 !dec_valid_q;
    endproperty
    a_addr: assert property (p_addr)
        else $error("clause address not presented with decode");

    // ------------------------------
    // clause traffic
    // ------------------------------
    property p_ps;
        predicate_set_op_op && !in_ready |=> ps_valid_q;
    endproperty
    a_ps: assert property (p_ps)
        else $error("predicate op not reported");
    property p_end;
        clause_done && !in_ready |=> end_valid_q && in_ready
            ##1 !end_valid_q;
    endproperty
    a_end: assert property (p_end)
        else $error("clause end not reported once");
endmodule

bind acfd_decoder acfd_checker u_chk (
    .clock(clock), .rst_b(rst_b), .in_valid(in_valid),
    .in_ready(in_ready), .in_word_lo(in_word_lo),
    .in_word_hi(in_word_hi), .predicate_set_op_op(predicate_set_op_op),
    .clause_done(clause_done), .dec_valid_q(dec_valid_q),
    .clause_addr_q(clause_addr_q),
    .addr_is_loop_end_q(addr_is_loop_end_q),
    .start_push_q(start_push_q), .else_after_q(else_after_q),
    .pop_after_q(pop_after_q), .pred_mode_q(pred_mode_q),
    .ps_valid_q(ps_valid_q), .end_valid_q(end_valid_q)
);
`default_nettype wire

/* verif/acfd_engine.sv */
// clause execution engine model: predicate ops then clause end
`timescale 1ns/1ps
`default_nettype none
module acfd_engine (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic slow,
    input wire logic [3:0] n_ops,
    output logic predicate_set_op_op,
    output logic clause_done
);
    logic [3:0] left_q;
    logic busy_q;
    logic gap_q;
    // slow mode idles a cycle before each op to stretch the clause
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
            gap_q <= 1'b0;
            left_q <= 4'h0;
            predicate_set_op_op <= 1'b0;
            clause_done <= 1'b0;
        end else begin
            predicate_set_op_op <= 1'b0;
            clause_done <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                left_q <= n_ops;
            end else if (busy_q && slow && !gap_q) begin
                gap_q <= 1'b1;
            end else if (busy_q && left_q != 4'h0) begin
                predicate_set_op_op <= 1'b1;
                left_q <= left_q - 4'h1;
                gap_q <= 1'b0;
            end else if (busy_q) begin
                clause_done <= 1'b1;
                busy_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/acfd_decoder_bench.sv */
// self-checking bench for the clause flow decoder
`timescale 1ns/1ps
`default_nettype none
module acfd_decoder_bench;
    logic clock, rst_b, in_valid, slow;
    logic [31:0] in_word_lo, in_word_hi;
    logic [3:0] n_ops;
    wire predicate_set_op_op, clause_done, in_ready, dec_valid_q, bad_op_q;
    wire addr_is_loop_end_q, start_push_q, else_after_q, four_word_q;
    wire ps_valid_q, ps_push_q, ps_update_q, ps_break_q, ps_cont_q;
    wire end_valid_q, end_else_q, end_cont_q;
    wire [1:0] pop_after_q, end_pop_q;
    wire [2:0] pred_mode_q;
    wire [21:0] clause_addr_q;
    wire [6:0] clause_count_q;
    wire [15:0] cb_bank_q, cb_idx_sel_q;
    wire [31:0] cb_addr_q;
    wire [7:0] cb_mode_q;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_push, n_upd, n_brk, n_cont;

    acfd_decoder u_dut (
        .clock(clock), .rst_b(rst_b), .in_valid(in_valid),
        .in_ready(in_ready), .in_word_lo(in_word_lo),
        .in_word_hi(in_word_hi), .predicate_set_op_op(predicate_set_op_op),
        .clause_done(clause_done), .dec_valid_q(dec_valid_q),
        .bad_op_q(bad_op_q), .clause_addr_q(clause_addr_q),
        .clause_count_q(clause_count_q),
        .addr_is_loop_end_q(addr_is_loop_end_q),
        .start_push_q(start_push_q), .else_after_q(else_after_q),
        .pop_after_q(pop_after_q), .pred_mode_q(pred_mode_q),
        .four_word_q(four_word_q), .cb_bank_q(cb_bank_q),
        .cb_addr_q(cb_addr_q), .cb_mode_q(cb_mode_q),
        .cb_idx_sel_q(cb_idx_sel_q), .ps_valid_q(ps_valid_q),
        .ps_push_q(ps_push_q), .ps_update_q(ps_update_q),
        .ps_break_q(ps_break_q), .ps_cont_q(ps_cont_q),
        .end_valid_q(end_valid_q), .end_else_q(end_else_q),
        .end_cont_q(end_cont_q), .end_pop_q(end_pop_q)
    );
    acfd_engine u_eng (
        .clock(clock), .rst_b(rst_b), .start(dec_valid_q),
        .slow(slow), .n_ops(n_ops), .predicate_set_op_op(predicate_set_op_op),
        .clause_done(clause_done)
    );

    // ------------------------------
    // clock, pulse tally, hang guard
    // ------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // tally action pulses so a clause can be judged as a whole
    always @(posedge clock) begin
        n_push += (ps_valid_q & ps_push_q);
        n_upd += (ps_valid_q & ps_update_q);
        n_brk += (ps_valid_q & ps_break_q);
        n_cont += (ps_valid_q & ps_cont_q);
        cycles += 1;
        if (cycles > 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // idle words are inverted so stale data cannot look valid
    task automatic send(input logic [31:0] lo, input logic [31:0] hi);
        @(posedge clock);
        in_valid <= 1'b1;
        in_word_lo <= lo;
        in_word_hi <= hi;
        @(posedge clock);
        in_valid <= 1'b0;
        in_word_lo <= ~lo;
        in_word_hi <= ~hi;
        #1;
    endtask
    function automatic logic [31:0] hw(input logic [3:0] op);
        return {2'b00, op, 1'b0, 7'h05, 18'h0_0000};
    endfunction
    task automatic run(input logic [31:0] lo, input logic [31:0] hi,
                       input logic [3:0] ops);
        int k;
        n_push = 0;
        n_upd = 0;
        n_brk = 0;
        n_cont = 0;
        n_ops = ops;
        send(lo, hi);
        chk(dec_valid_q, 1);
        for (k = 0; k < 60 && end_valid_q !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        chk(end_valid_q, 1);
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_plain;
        run(32'h0012_3456, hw(4'h8), 4'h3);
        chk(clause_addr_q, 22'h12_3456);
        chk(clause_count_q, 7'h05);
        chk({n_push[15:0], n_upd[15:0]}, {16'h0000, 16'h0003});
        chk({end_else_q, end_pop_q}, 0);
        chk(cb_idx_sel_q, 0);
        send(32'h0000_0000, hw(4'h2));
        chk({bad_op_q, dec_valid_q}, 2'b10);
        $display("plain start done");
    endtask
    task automatic t_first;
        slow = 1'b1;
        run(32'h0000_0040, hw(4'h9), 4'h3);
        slow = 1'b0;
        chk({n_push[15:0], n_upd[15:0]}, {16'h0001, 16'h0003});
        $display("first push done");
    endtask
    task automatic t_pops;
        run(32'h0000_0000, hw(4'hA), 4'h1);
        chk(end_pop_q, 2'h1);
        run(32'h0000_0000, hw(4'hB), 4'h0);
        chk(end_pop_q, 2'h2);
        $display("pops done");
    endtask
    task automatic t_loop;
        for (int i = 0; i < 2; i++) begin
            run(32'h0000_0100, hw(i ? 4'hE : 4'hD), 4'h2);
            chk(addr_is_loop_end_q, 1);
            chk({start_push_q, end_else_q, end_cont_q}, 3'b111);
            chk(end_pop_q, 2'h1);
            chk(n_brk, i ? 2 : 0);
            chk(n_cont, i ? 0 : 2);
        end
        $display("loop variants done");
    endtask
    task automatic t_invert;
        run(32'h0000_0000, hw(4'hF), 4'h2);
        chk({n_push[15:0], n_upd[15:0]}, {16'h0002, 16'h0002});
        chk({end_else_q, end_pop_q}, 3'b100);
        $display("push invert done");
    endtask
    task automatic t_four;
        send(32'h9D0A_BCD0, 32'h30CC_8885);
        chk({dec_valid_q, in_ready}, 2'b01);
        run(32'hC840_1234, 32'h200A_4512, 4'h1);
        chk(four_word_q, 1);
        chk(cb_bank_q, 16'h7421);
        chk(cb_addr_q, 32'h2221_9144);
        chk(cb_mode_q, 8'h6B);
        chk(cb_idx_sel_q, 16'hABCD);
        $display("four word done");
    endtask

    // ------------------------------
    // sequence and verdict
    // ------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        in_valid = 1'b0;
        in_word_lo = 32'h0000_0000;
        in_word_hi = 32'h0000_0000;
        n_ops = 4'h0;
        slow = 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        t_plain();
        t_first();
        t_pops();
        t_loop();
        t_invert();
        t_four();
        report_and_stop();
    end
endmodule
`default_nettype wire
